/* File: logic/parallel_printer_port.v */
`timescale 1ns/1ps
`include "parallel_port_map.vh"

module parallel_printer_port #(
   parameter ADDR_WIDTH = 10
) (
   input wire core_clk_i, // Core clock, 25 MHz
   input wire reset_n_i, // Asynchronous reset, active low
   input wire [ADDR_WIDTH-1:0] base_addr_i, // Port base address from configuration
   input wire [ADDR_WIDTH-1:0] addr_i, // Register bus address
   input wire [7:0] wr_data_i, // Register bus write data
   input wire wr_i, // Write strobe, one cycle
   input wire rd_i, // Read strobe, one cycle
   output reg [7:0] rd_data_o, // Read data, valid the cycle after rd_i
   input wire [7:0] pdata_i, // Data pin levels
   output wire [7:0] pdata_o, // Data pin drive value
   output wire pdata_oe_o, // Data pin output enable
   input wire busy_flag_i, // Busy pin
   input wire acknowledge_flag_i, // Acknowledge pin
   input wire media_out_flag_i, // Paper-end pin
   input wire online_in_pin_i, // Online-select pin
   input wire fault_flag_i, // Error pin level
   output wire fault_flag_o, // Error pin drive value, scanner mode
   output wire fault_flag_oe_o, // Error pin output enable
   output wire data_clock_pulse_o, // Strobe pin
   output wire init_pin_o, // Init pin
   output wire feed_out_pin_o, // Auto-feed pin
   output wire select_out_pin_o, // Select-in pin
   output wire irq_o, // Interrupt request, level
   output wire scanner_mode_o // High while in scanner mode
);

   // =======================================================================
   // Address decode
   // =======================================================================
   wire [ADDR_WIDTH-1:0] rel_addr;
   wire hit;
   wire [1:0] ofs;

   // Offset from base; any address outside the four-byte window misses
   function in_window;
      input [ADDR_WIDTH-1:0] rel;
      begin
         in_window = (rel[ADDR_WIDTH-1:2] == {(ADDR_WIDTH-2){1'b0}});
      end
   endfunction

   assign rel_addr = addr_i - base_addr_i;
   assign hit = in_window(rel_addr);
   assign ofs = rel_addr[1:0];

   wire wr_data_sel;
   wire wr_ctrl_sel;
   wire wr_cfg_sel;
   wire rd_sel;

   assign wr_data_sel = wr_i && hit && (ofs == `PP_OFS_DATA);
   assign wr_ctrl_sel = wr_i && hit && (ofs == `PP_OFS_CONTROL);
   assign wr_cfg_sel = wr_i && hit && (ofs == `PP_OFS_CONFIG);
   assign rd_sel = rd_i && hit;

   // =======================================================================
   // Pin synchronisers
   // =======================================================================
   wire [7:0] pdata_s;
   wire [4:0] stat_s;
   wire busy_s;
   wire ack_s;
   wire media_s;
   wire online_s;
   wire fault_s;

   pin_sync #(
      .WIDTH(8)
   ) u_data_sync (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .async_i(pdata_i),
      .sync_o(pdata_s)
   );

   pin_sync #(
      .WIDTH(5)
   ) u_stat_sync (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .async_i({busy_flag_i, acknowledge_flag_i, media_out_flag_i,
                online_in_pin_i, fault_flag_i}),
      .sync_o(stat_s)
   );

   assign busy_s = stat_s[4];
   assign ack_s = stat_s[3];
   assign media_s = stat_s[2];
   assign online_s = stat_s[1];
   assign fault_s = stat_s[0];

   // =======================================================================
   // Registers
   // =======================================================================
   reg [7:0] data_latch_r;
   reg [7:0] ctrl_r;
   reg [7:0] cfg_r;
   reg [7:0] ctrl_nxt;
   wire scanner;

   assign scanner = cfg_r[`PP_CF_SCANNER];

   // Offset 1 has no write path, so writes there are dropped
   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         data_latch_r <= `PP_RST_DATA;
      end else if (wr_data_sel) begin
         data_latch_r <= wr_data_i;
      end
   end

   // Reserved control bits never store a one; bit 7 only exists in scanner mode
   always @* begin
      if (scanner) begin
         ctrl_nxt = wr_data_i & `PP_CT_SCAN_MASK;
      end else begin
         ctrl_nxt = wr_data_i & `PP_CT_USED_MASK;
      end
   end

   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_r <= `PP_RST_CONTROL;
      end else if (wr_ctrl_sel) begin
         ctrl_r <= ctrl_nxt;
      end else if (!scanner) begin
         ctrl_r[`PP_CT_BUSY_OUT] <= 1'b0;
      end
   end

   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cfg_r <= `PP_RST_CONFIG;
      end else if (wr_cfg_sel) begin
         cfg_r <= wr_data_i & `PP_CF_MASK;
      end
   end

   // =======================================================================
   // Read path
   // =======================================================================
   function [7:0] printer_status;
      input b;
      input a;
      input m;
      input o;
      input f;
      begin
         printer_status = 8'h00;
         printer_status[`PP_ST_BUSY] = b;
         printer_status[`PP_ST_ACK] = a;
         printer_status[`PP_ST_MEDIA] = m;
         printer_status[`PP_ST_ONLINE] = o;
         printer_status[`PP_ST_FAULT] = ~f;
      end
   endfunction

   function [7:0] scanner_status;
      input b;
      input a;
      input m;
      input o;
      begin
         scanner_status = 8'h00;
         scanner_status[`PP_ST_BUSY] = b;
         scanner_status[`PP_ST_ACK] = a;
         scanner_status[`PP_SST_FAULT] = m;
         scanner_status[`PP_ST_ONLINE] = o;
         scanner_status[`PP_SST_STROBE] = o;
      end
   endfunction

   reg [7:0] rd_nxt;

   always @* begin
      rd_nxt = 8'h00;
      if (!rd_sel) begin
         rd_nxt = 8'h00;
      end else if (ofs == `PP_OFS_DATA) begin
         // Printer mode reads back the latch, never the pins
         rd_nxt = scanner ? pdata_s : data_latch_r;
      end else if (ofs == `PP_OFS_STATUS) begin
         if (scanner) begin
            rd_nxt = scanner_status(busy_s, ack_s, media_s, online_s);
         end else begin
            rd_nxt = printer_status(busy_s, ack_s, media_s, online_s, fault_s);
         end
      end else if (ofs == `PP_OFS_CONTROL) begin
         rd_nxt = ctrl_r;
      end else begin
         rd_nxt = cfg_r;
      end
   end

   // Read data stand for exactly one cycle, zero otherwise
   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rd_data_o <= 8'h00;
      end else begin
         rd_data_o <= rd_nxt;
      end
   end

   // =======================================================================
   // Interrupt
   // =======================================================================
   reg irq_r;

   // Level follows a deasserted (high) acknowledge while enabled
   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= ctrl_r[`PP_CT_IRQ_EN] & ack_s;
      end
   end

   assign irq_o = irq_r;

   // =======================================================================
   // Pin drive
   // =======================================================================
   // Strobe width and data setup are software's job; the pin is a plain copy
   assign pdata_o = data_latch_r;
   // Scanner direction follows the auto-feed control bit (bit 1); printer mode always drives
   assign pdata_oe_o = scanner ? ctrl_r[`PP_CT_FEED] : 1'b1;
   assign data_clock_pulse_o = ctrl_r[`PP_CT_STROBE];
   assign init_pin_o = ~ctrl_r[`PP_CT_INIT];
   assign feed_out_pin_o = ctrl_r[`PP_CT_FEED];
   assign select_out_pin_o = ctrl_r[`PP_CT_SELECT];
   assign fault_flag_o = ctrl_r[`PP_CT_BUSY_OUT];
   assign fault_flag_oe_o = scanner;
   assign scanner_mode_o = scanner;

endmodule // parallel_printer_port

/* File: logic/parallel_port_map.vh */
`ifndef PARALLEL_PORT_MAP_VH
`define PARALLEL_PORT_MAP_VH

// ==========================================================================
// Register offsets from the port base address
// ==========================================================================
`define PP_OFS_DATA 2'h0
`define PP_OFS_STATUS 2'h1
`define PP_OFS_CONTROL 2'h2
`define PP_OFS_CONFIG 2'h3

// ==========================================================================
// Status register fields, printer layout
// ==========================================================================
`define PP_ST_BUSY 7
`define PP_ST_ACK 6
`define PP_ST_MEDIA 5
`define PP_ST_ONLINE 4
`define PP_ST_FAULT 3

// ==========================================================================
// Status register fields, scanner layout
// ==========================================================================
`define PP_SST_FAULT 5
`define PP_SST_STROBE 0

// ==========================================================================
// Control register fields
// ==========================================================================
`define PP_CT_BUSY_OUT 7
`define PP_CT_IRQ_EN 4
`define PP_CT_SELECT 3
`define PP_CT_INIT 2
`define PP_CT_FEED 1
`define PP_CT_STROBE 0
`define PP_CT_USED_MASK 8'h1f
`define PP_CT_SCAN_MASK 8'h9f

// ==========================================================================
// Configuration register fields
// ==========================================================================
`define PP_CF_SCANNER 6
`define PP_CF_MASK 8'h40

// ==========================================================================
// Reset values
// ==========================================================================
`define PP_RST_DATA 8'h00
`define PP_RST_CONTROL 8'h00
`define PP_RST_CONFIG 8'h00

`endif

/* File: logic/pin_sync.v */
`timescale 1ns/1ps

// ==========================================================================
// Two-stage synchroniser for a group of pin inputs
// ==========================================================================
module pin_sync #(
   parameter WIDTH = 8
) (
   input wire core_clk_i, // Core clock
   input wire reset_n_i, // Asynchronous reset, active low
   input wire [WIDTH-1:0] async_i, // Pin levels from outside the domain
   output wire [WIDTH-1:0] sync_o // Levels after two flip-flops
);

   reg [WIDTH-1:0] meta_r;
   reg [WIDTH-1:0] sync_r;

   // The first stage is read only by the second stage
   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_r <= {WIDTH{1'b0}};
         sync_r <= {WIDTH{1'b0}};
      end else begin
         meta_r <= async_i;
         sync_r <= meta_r;
      end
   end

   assign sync_o = sync_r;

endmodule // pin_sync

/* File: test/pp_chk.sv */
`timescale 1ns/1ps
`include "parallel_port_map.vh"
module pp_chk #(parameter ADDR_WIDTH = 10) (
   input wire core_clk_i, // Clock
   input wire reset_n_i, // Reset, active low
   input wire [ADDR_WIDTH-1:0] base_addr_i, // Base
   input wire [ADDR_WIDTH-1:0] addr_i, // Address
   input wire [7:0] wr_data_i, // Write data
   input wire wr_i, // Write strobe
   input wire rd_i, // Read strobe
   input wire [7:0] rd_data_o, // Read data
   input wire [7:0] pdata_o, // Data pins
   input wire pdata_oe_o, // Data enable
   input wire busy_flag_i, // Busy pin
   input wire acknowledge_flag_i, // Ack pin
   input wire media_out_flag_i, // Paper pin
   input wire online_in_pin_i, // Online pin
   input wire fault_flag_i, // Error pin
   input wire data_clock_pulse_o, // Strobe pin
   input wire init_pin_o, // Init pin
   input wire feed_out_pin_o, // Feed pin
   input wire select_out_pin_o, // Select pin
   input wire irq_o, // Interrupt
   input wire scanner_mode_o // Mode
);
   // ==========
   // Decode and pin settling
   // ==========
   wire [ADDR_WIDTH-1:0] rel = addr_i - base_addr_i;
   wire pm = !scanner_mode_o;
   wire [4:0] pins = {busy_flag_i, acknowledge_flag_i, media_out_flag_i, online_in_pin_i,
      fault_flag_i};
   reg [4:0] prev_r;
   reg [1:0] cnt_r;
   // Pins count as settled only once they got through both sync stages
   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         prev_r <= 5'h00;
         cnt_r <= 2'h0;
      end else begin
         prev_r <= pins;
         cnt_r <= (pins != prev_r) ? 2'h0 : ((cnt_r == 2'h3) ? 2'h3 : cnt_r + 2'h1);
      end
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   // ==========
   // Properties
   // ==========
   a_data_drive: assert property (
      wr_i && rel == `PP_OFS_DATA |=> pdata_o == $past(wr_data_i))
      else $error("data pins");
   a_data_back: assert property (
      rd_i && rel == `PP_OFS_DATA && pm |=> rd_data_o == pdata_o)
      else $error("data readback");
   a_status_ro: assert property (
      wr_i && rel == `PP_OFS_STATUS |=> $stable({pdata_o, data_clock_pulse_o, init_pin_o,
      feed_out_pin_o, select_out_pin_o, scanner_mode_o}))
      else $error("status write");
   a_status_pins: assert property (
      rd_i && rel == `PP_OFS_STATUS && pm && cnt_r == 2'h3
      |=> rd_data_o == {$past(pins[4:1]), !$past(fault_flag_i), 3'h0})
      else $error("status bits");
   a_ctrl_pins: assert property (
      wr_i && rel == `PP_OFS_CONTROL |=> {select_out_pin_o, init_pin_o, feed_out_pin_o,
      data_clock_pulse_o} == ($past(wr_data_i[3:0]) ^ 4'h4))
      else $error("control pins");
   a_ctrl_resv: assert property (
      rd_i && rel == `PP_OFS_CONTROL && pm |=> rd_data_o[7:5] == 3'h0)
      else $error("control reserved");
   a_irq_off: assert property (
      wr_i && rel == `PP_OFS_CONTROL && !wr_data_i[4] |-> ##2 !irq_o)
      else $error("irq masked");
   a_irq_on: assert property (
      wr_i && rel == `PP_OFS_CONTROL && wr_data_i[4] && cnt_r == 2'h3 && acknowledge_flag_i
      |-> ##2 irq_o)
      else $error("irq enabled");
   a_oe_print: assert property (
      pm |-> pdata_oe_o)
      else $error("data enable");
   a_mode_cfg: assert property (
      wr_i && rel == `PP_OFS_CONFIG |=> scanner_mode_o == $past(wr_data_i[`PP_CF_SCANNER]))
      else $error("mode bit");
   a_read_out: assert property (
      rd_i && rel > 3 |=> rd_data_o == 8'h00)
      else $error("outside window");
endmodule // pp_chk

/* File: test/printer_model.sv */
`timescale 1ns/1ps
module printer_model (
   input wire core_clk_i, // Clock
   input wire reset_n_i, // Reset, active low
   input wire data_clock_pulse_i, // Strobe pin
   input wire [7:0] pdata_i, // Data pins
   output reg busy_flag_o, // Low while busy
   output reg acknowledge_flag_o, // Low once byte taken
   output reg [7:0] byte_o // Last byte clocked in
);
   reg stb_r;
   reg [3:0] cnt_r;
   wire fall = stb_r && !data_clock_pulse_i;
   // Takes the byte on the strobe rise, answers with ack low after it falls
   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         stb_r <= 1'b0;
         cnt_r <= 4'h0;
         busy_flag_o <= 1'b1;
         acknowledge_flag_o <= 1'b1;
         byte_o <= 8'h00;
      end else begin
         stb_r <= data_clock_pulse_i;
         if (data_clock_pulse_i && !stb_r) begin
            byte_o <= pdata_i;
            busy_flag_o <= 1'b0;
         end
         cnt_r <= fall ? 4'h8 : ((cnt_r != 4'h0) ? cnt_r - 4'h1 : 4'h0);
         acknowledge_flag_o <= (cnt_r == 4'h0);
         if (cnt_r == 4'h1) busy_flag_o <= 1'b1;
      end
   end
endmodule // printer_model

/* File: test/parallel_printer_port_tb.sv */
`timescale 1ns/1ps
`include "parallel_port_map.vh"
module parallel_printer_port_tb;
   reg core_clk_i = 0, reset_n_i = 0, wr_i = 0, rd_i = 0;
   reg media_out_flag_i = 0, online_in_pin_i = 0, fault_flag_i = 0;
   reg [9:0] base_addr_i = 10'h120, addr_i = 10'h000;
   reg [7:0] wr_data_i = 8'h00, d;
   wire [7:0] rd_data_o, pdata_o, pdata_i, byte_o;
   wire pdata_oe_o, busy_flag_i, acknowledge_flag_i, fault_flag_o, fault_flag_oe_o, irq_o;
   wire data_clock_pulse_o, init_pin_o, feed_out_pin_o, select_out_pin_o, scanner_mode_o;
   integer miscompares = 0, n_compared = 0, i;
   reg [7:0] rw [0:4] = '{8'h00, 8'h08, 8'h04, 8'h02, 8'he0};
   reg [3:0] rp [0:4] = '{4'h4, 4'hc, 4'h0, 4'h6, 4'h4};
   assign pdata_i = pdata_o;
   parallel_printer_port dut (.*);
   printer_model prn (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
      .data_clock_pulse_i(data_clock_pulse_o), .pdata_i(pdata_o), .busy_flag_o(busy_flag_i),
      .acknowledge_flag_o(acknowledge_flag_i), .byte_o(byte_o));
   always #20 core_clk_i = ~core_clk_i;
   // ==========
   // Tasks
   // ==========
   task chk(input [7:0] seen, input [7:0] exp);
      n_compared = n_compared + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task bus(input w, input [9:0] o, input [7:0] v);
      @(posedge core_clk_i);
      addr_i <= base_addr_i + o;
      wr_data_i <= v;
      wr_i <= w;
      rd_i <= !w;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      #1 d = rd_data_o;
   endtask
   task end_sim;
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk_i);
      miscompares = miscompares + 1;
      end_sim;
   end
   // ==========
   // Main sequence
   // ==========
   initial begin
      repeat (10) @(posedge core_clk_i);
      chk(pdata_o, 8'h00);
      chk({4'h0, init_pin_o, select_out_pin_o, feed_out_pin_o, data_clock_pulse_o}, 8'h08);
      reset_n_i <= 1'b1;
      bus(0, `PP_OFS_CONTROL, 0);
      chk(d, `PP_RST_CONTROL);
      for (i = 0; i < 5; i = i + 1) begin
         bus(1, `PP_OFS_CONTROL, rw[i]);
         chk({4'h0, select_out_pin_o, init_pin_o, feed_out_pin_o, data_clock_pulse_o},
            {4'h0, rp[i]});
         bus(0, `PP_OFS_CONTROL, 0);
         chk(d, rw[i] & 8'h1f);
      end
      bus(1, `PP_OFS_DATA, 8'h3c);
      bus(1, `PP_OFS_DATA, 8'hc3);
      chk(pdata_o, 8'hc3);
      bus(0, `PP_OFS_DATA, 0);
      chk(d, 8'hc3);
      bus(1, `PP_OFS_STATUS, 8'hff);
      bus(1, 10'h5, 8'h00);
      chk(pdata_o, 8'hc3);
      bus(0, 10'h4, 0);
      chk(d, 8'h00);
      for (i = 0; i < 8; i = i + 1) begin
         {media_out_flag_i, online_in_pin_i, fault_flag_i} <= i[2:0];
         repeat (4) @(posedge core_clk_i);
         bus(0, `PP_OFS_STATUS, 0);
         chk(d, {2'h3, i[2:1], ~i[0], 3'h0});
      end
      bus(1, `PP_OFS_DATA, 8'ha5);
      bus(1, `PP_OFS_CONTROL, 8'h10);
      repeat (13) @(posedge core_clk_i);
      chk({7'h0, irq_o}, 8'h01);
      bus(1, `PP_OFS_CONTROL, 8'h11);
      repeat (4) @(posedge core_clk_i);
      bus(0, `PP_OFS_STATUS, 0);
      chk({7'h0, d[7]}, 8'h00);
      repeat (13) @(posedge core_clk_i);
      bus(1, `PP_OFS_CONTROL, 8'h10);
      chk(byte_o, 8'ha5);
      repeat (7) @(posedge core_clk_i);
      #1 chk({7'h0, irq_o}, 8'h00);
      repeat (20) @(posedge core_clk_i);
      #1 chk({7'h0, irq_o}, 8'h01);
      bus(1, `PP_OFS_CONTROL, 8'h00);
      chk({7'h0, init_pin_o}, 8'h01);
      repeat (1250) @(posedge core_clk_i);
      #1 chk({7'h0, irq_o}, 8'h00);
      bus(1, `PP_OFS_CONTROL, 8'h04);
      chk({7'h0, init_pin_o}, 8'h00);
      bus(1, `PP_OFS_CONFIG, 8'h40);
      chk({7'h0, scanner_mode_o}, 8'h01);
      // Scanner mode: busy-out bit, direction and the scanner status layout
      bus(1, `PP_OFS_CONTROL, 8'h82);
      chk({5'h0, fault_flag_o, fault_flag_oe_o, pdata_oe_o}, 8'h07);
      bus(0, `PP_OFS_DATA, 0);
      chk(d, 8'ha5);
      bus(0, `PP_OFS_STATUS, 0);
      chk(d, 8'hf1);
      bus(1, `PP_OFS_CONTROL, 8'h80);
      chk({7'h0, pdata_oe_o}, 8'h00);
      bus(1, `PP_OFS_CONFIG, 8'h00);
      chk({6'h0, scanner_mode_o, pdata_oe_o}, 8'h01);
      chk({7'h0, fault_flag_oe_o}, 8'h00);
      bus(0, `PP_OFS_CONTROL, 0);
      chk(d, 8'h00);
      chk({7'h0, fault_flag_o}, 8'h00);
      bus(1, `PP_OFS_CONTROL, 8'h1f);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      #1 chk({4'h0, init_pin_o, select_out_pin_o, feed_out_pin_o, data_clock_pulse_o},
         8'h08);
      reset_n_i <= 1'b1;
      bus(0, `PP_OFS_CONTROL, 0);
      chk(d, 8'h00);
      end_sim;
   end
endmodule // parallel_printer_port_tb
bind parallel_printer_port pp_chk #(.ADDR_WIDTH(ADDR_WIDTH)) chk_i (.*);
